//--- logic/prox_consts.svh
/*
 * Register offsets, status field positions and reset values of the proximity readout.
 * Assumes it is included by its bare name in each design file that needs the numbers.
 */
`ifndef PROX_CONSTS_SVH
`define PROX_CONSTS_SVH

`define REG_FLAGS        8'h13
`define REG_LOW          8'h18
`define REG_HIGH         8'h19
`define REG_TRIM         8'h1e

`define FLAG_SAT_BIT     6
`define FLAG_INT_BIT     5
`define FLAG_VALID_BIT   1
`define FLAGS_RSVD_MASK  8'h9d

`define TRIM_SIGN_BIT    7
`define TRIM_RESET       8'h00
`define RDATA_RESET      8'h00
`define RESULT_RESET     16'h0000
`define RESULT_MAX       16'hffff

`endif

//--- logic/prox_pkg.sv
/*
 * Types shared by the proximity readout: register select, conversion and setting carriers.
 * Assumes nothing of its surroundings.
 */
package prox_pkg;

	typedef enum logic [2:0] {
		SEL_FLAGS,
		SEL_LOW,
		SEL_HIGH,
		SEL_TRIM,
		SEL_NONE
	} reg_sel_e;

	typedef struct packed {
		logic [15:0] raw;
		logic        sat;
	} conv_s;

	typedef struct packed {
		logic [1:0]  front_end_gain_select;
		logic [1:0]  emitter_current_select;
		logic [7:0]  emitter_pulse_count;
		logic [3:0]  interrupt_filter_count;
		logic        int_enable;
		logic [15:0] thr_low;
		logic [15:0] thr_high;
	} cfg_s;

	typedef struct packed {
		logic        sat;
		logic [15:0] value;
	} trimmed_s;

endpackage

//--- logic/prox_readout.sv
/*
 * Proximity readout: status flags, trimmed 16-bit result with coherent byte reads,
 * offset trim register and the persistence-filtered interrupt pin.
 * Assumes a byte register port from the serial interface, one strobe per byte access,
 * and a conversion strobe with raw data from the analogue front end, all on CLK_SYS.
 */
`timescale 1ns/10ps
`include "prox_consts.svh"

// Function
// - Status register is read only; writes never change its flags.
// - Status bit 6 reads one when the latest measurement saturated.
// - Status bit 5 reads one while the interrupt pin is driven asserted.
// - Status bit 1 reads one once a conversion has completed with valid data.
// - Result is 16 bits, low byte at 0x18 and high byte at 0x19.
// - Reading the low byte captures the upper byte into a shadow for the high read.
// - Conversions between the two byte reads never overwrite the shadowed upper byte.
// - Offset trim is 8-bit sign-magnitude, bit 7 the sign.
// - Sign zero shifts the result down, sign one shifts it up.
// - Seven-bit magnitude sets how far the result is shifted.
// - Shift per magnitude step scales with gain, emitter current and pulse count.
// - Persistence zero interrupts every conversion; 1 to 15 need that many out of range.

module prox_readout
	import prox_pkg::*;
(
	input  wire logic        CLK_SYS,
	input  wire logic        RESET,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [7:0]  REG_RDATA,
	input  wire logic        CONV_DONE,
	input  wire conv_s       CONV,
	input  wire cfg_s        CFG,
	input  wire logic        INT_CLEAR,
	output logic             INT_N_OUT,
	output logic             INT_N_OE
);

	function automatic reg_sel_e reg_decode(input logic [7:0] addr);
		case (addr)
			`REG_FLAGS: reg_decode = SEL_FLAGS;
			`REG_LOW:   reg_decode = SEL_LOW;
			`REG_HIGH:  reg_decode = SEL_HIGH;
			`REG_TRIM:  reg_decode = SEL_TRIM;
			default:    reg_decode = SEL_NONE;
		endcase
	endfunction

	// One magnitude step: pulses times gain times relative emitter current, over eight.
	function automatic logic [10:0] trim_step(input logic [1:0] gain,
	                                          input logic [1:0] drive,
	                                          input logic [7:0] pulses);
		logic [13:0] prod;
		prod = ({6'h00, pulses} << gain) << (2'd3 - drive);
		trim_step = prod[13:3];
	endfunction

	// Applies the signed shift and clamps at both ends of the 16-bit range.
	function automatic trimmed_s apply_trim(input logic [15:0] raw,
	                                        input logic [7:0]  trim,
	                                        input logic [10:0] step);
		logic [17:0] shift;
		logic [18:0] sum;
		logic [17:0] diff;
		shift = 18'(trim[6:0]) * 18'(step);
		sum = {3'b000, raw} + {1'b0, shift};
		diff = {2'b00, raw} - shift;
		apply_trim.sat = 1'b0;
		if (trim[`TRIM_SIGN_BIT]) begin
			if (sum > {3'b000, `RESULT_MAX}) begin
				apply_trim.value = `RESULT_MAX;
				apply_trim.sat = 1'b1;
			end else begin
				apply_trim.value = sum[15:0];
			end
		end else if ({2'b00, raw} < shift) begin
			apply_trim.value = `RESULT_RESET;
		end else begin
			apply_trim.value = diff[15:0];
		end
	endfunction

	logic [7:0]  trim;
	logic [15:0] result;
	logic        sat_flag;
	logic        valid_flag;
	logic        int_flag;
	logic [3:0]  pers_cnt;
	logic [7:0]  shadow_high;
	logic [7:0]  flags_view;
	trimmed_s    next_trimmed;
	reg_sel_e    sel;
	logic        low_read;
	logic        out_of_range;
	logic        fire;

	assign sel = reg_decode(REG_ADDR);
	assign low_read = REG_RD && (sel == SEL_LOW);

	assign next_trimmed = apply_trim(CONV.raw, trim,
		trim_step(CFG.front_end_gain_select, CFG.emitter_current_select,
		          CFG.emitter_pulse_count));

	assign out_of_range = (next_trimmed.value < CFG.thr_low) ||
	                      (next_trimmed.value > CFG.thr_high);

	assign fire = CONV_DONE && CFG.int_enable &&
		((CFG.interrupt_filter_count == 4'h0) ||
		 (out_of_range && ({1'b0, pers_cnt} + 5'd1 >= {1'b0, CFG.interrupt_filter_count})));

	always_comb begin
		flags_view = 8'h00;
		flags_view[`FLAG_SAT_BIT] = sat_flag;
		flags_view[`FLAG_INT_BIT] = int_flag;
		flags_view[`FLAG_VALID_BIT] = valid_flag;
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			trim <= `TRIM_RESET;
		end else if (REG_WR && (sel == SEL_TRIM)) begin
			trim <= REG_WDATA;
		end
	end

	// Status flags take no write path at all.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			result <= `RESULT_RESET;
			sat_flag <= 1'b0;
			valid_flag <= 1'b0;
		end else if (CONV_DONE) begin
			result <= next_trimmed.value;
			sat_flag <= CONV.sat || next_trimmed.sat;
			valid_flag <= 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			pers_cnt <= 4'h0;
		end else if (CONV_DONE) begin
			if (!out_of_range) begin
				pers_cnt <= 4'h0;
			end else if (pers_cnt != 4'hf) begin
				pers_cnt <= pers_cnt + 4'h1;
			end
		end
	end

	// A new interrupt in the clear cycle wins, so no event is lost.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			int_flag <= 1'b0;
		end else if (fire) begin
			int_flag <= 1'b1;
		end else if (INT_CLEAR) begin
			int_flag <= 1'b0;
		end
	end

	result_shadow u_shadow (
		.clk         (CLK_SYS),
		.reset       (RESET),
		.live        (result),
		.capture     (low_read),
		.shadow_high (shadow_high)
	);

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			REG_RDATA <= `RDATA_RESET;
		end else if (REG_RD) begin
			case (sel)
				SEL_FLAGS: REG_RDATA <= flags_view;
				SEL_LOW:   REG_RDATA <= result[7:0];
				SEL_HIGH:  REG_RDATA <= shadow_high;
				SEL_TRIM:  REG_RDATA <= trim;
				default:   REG_RDATA <= `RDATA_RESET;
			endcase
		end
	end

	// Open-drain pin: the low level is driven only while the interrupt stands.
	assign INT_N_OUT = 1'b0;
	assign INT_N_OE = int_flag;

	status_ro_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(REG_WR && sel == SEL_FLAGS && !CONV_DONE && !INT_CLEAR) |=> $stable(flags_view))
		else $error("status changed on a write");

	sat_flag_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(CONV_DONE && CONV.sat) |=> flags_view[`FLAG_SAT_BIT])
		else $error("saturation not flagged");

	int_mirror_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(REG_RD && sel == SEL_FLAGS) |=>
		REG_RDATA[`FLAG_INT_BIT] == $past(INT_N_OE && !INT_N_OUT))
		else $error("status interrupt bit differs from pin");

	valid_set_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		$rose(valid_flag) |-> $past(CONV_DONE))
		else $error("valid flag rose without a conversion");

	low_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		low_read |=> REG_RDATA == $past(result[7:0]))
		else $error("low byte read wrong");

	byte_pair_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(low_read ##1 (REG_RD && sel == SEL_HIGH)) |=>
		REG_RDATA == $past(result[15:8], 2))
		else $error("high byte not from the same result");

	trim_store_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(REG_WR && sel == SEL_TRIM) |=> trim == $past(REG_WDATA))
		else $error("trim register not written");

	trim_dir_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		CONV_DONE |=> ($past(trim[`TRIM_SIGN_BIT]) ? result >= $past(CONV.raw)
		                                            : result <= $past(CONV.raw)))
		else $error("trim shifted the wrong way");

	trim_zero_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(CONV_DONE && trim[6:0] == 7'h00) |=> result == $past(CONV.raw))
		else $error("zero magnitude changed the result");

	trim_scale_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(CONV_DONE && trim == 8'h81 && CFG.emitter_pulse_count == 8'h08 &&
		 CFG.front_end_gain_select == 2'b01 && CFG.emitter_current_select == 2'b00 &&
		 CONV.raw < 16'h8000) |=> result == $past(CONV.raw) + 16'h0010)
		else $error("trim step not scaled");

	pers_every_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(CONV_DONE && CFG.int_enable && CFG.interrupt_filter_count == 4'h0) |=> INT_N_OE)
		else $error("persistence zero did not interrupt");

	pers_cause_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		$rose(int_flag) |-> $past(CONV_DONE && CFG.int_enable))
		else $error("interrupt without a conversion");

	rsvd_zero_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(REG_RD && sel == SEL_FLAGS) |=> (REG_RDATA & `FLAGS_RSVD_MASK) == 8'h00)
		else $error("reserved status bit set");

endmodule

//--- logic/result_shadow.sv
/*
 * Shadow holder for the upper result byte, captured when the low byte is read.
 * Assumes capture is a one-cycle pulse in the cycle of the low-byte read.
 */
`timescale 1ns/10ps
`include "prox_consts.svh"

module result_shadow (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [15:0] live,
	input  wire logic        capture,
	output logic      [7:0]  shadow_high
);

	// Only a low-byte read moves the shadow, so later conversions cannot tear the pair.
	always_ff @(posedge clk) begin
		if (reset) begin
			shadow_high <= `RDATA_RESET;
		end else if (capture) begin
			shadow_high <= live[15:8];
		end
	end

	shadow_take_a: assert property (@(posedge clk) disable iff (reset)
		capture |=> shadow_high == $past(live[15:8]))
		else $error("shadow did not take the upper byte");

	shadow_hold_a: assert property (@(posedge clk) disable iff (reset)
		!capture |=> $stable(shadow_high))
		else $error("shadow changed without a low-byte read");

endmodule

//--- sim/host_model.sv
/*
 * Host side of the proximity readout: byte register reads and writes, the low-then-high
 * result fetch, and the pull-up resistor on the open-drain interrupt line.
 * Assumes one strobe cycle per byte and read data one cycle after the strobe edge.
 */
`timescale 1ns/10ps
`include "prox_consts.svh"

module host_model (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	input  wire logic       int_n_oe,
	input  wire logic       int_n_out,
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd,
	output wire logic       int_line
);
	// The line floats high through the pull-up whenever the device lets go of it.
	assign int_line = int_n_oe ? int_n_out : 1'b1;

	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
	endtask

	// One burst, low byte first, the way an auto-increment fetch arrives.
	task automatic read_result(output logic [15:0] v);
		@(posedge clk);
		addr <= `REG_LOW;
		rd <= 1'b1;
		@(posedge clk);
		addr <= `REG_HIGH;
		#1;
		v[7:0] = rdata;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~`REG_HIGH;
		#1;
		v[15:8] = rdata;
	endtask
endmodule

//--- sim/tb_prox_readout.sv
/*
 * Self-checking bench for the proximity readout: register traffic through the host model,
 * conversions driven here, expected values worked out by hand from the trim step formula.
 * Assumes the design files and host_model are compiled first.
 */
`timescale 1ns/10ps
`include "prox_consts.svh"

module tb_prox_readout
	import prox_pkg::*;
;
	logic        clk_sys;
	logic        reset;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        conv_done;
	conv_s       conv;
	cfg_s        cfg;
	logic        int_clear;
	logic        int_n_out;
	logic        int_n_oe;
	wire logic   int_line;
	logic [7:0]  b;
	logic [15:0] w;
	int          num_errors;
	int          checks;

	prox_readout i_dut (.CLK_SYS(clk_sys), .RESET(reset), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.CONV_DONE(conv_done), .CONV(conv), .CFG(cfg), .INT_CLEAR(int_clear),
		.INT_N_OUT(int_n_out), .INT_N_OE(int_n_oe));
	host_model i_host (.clk(clk_sys), .rdata(reg_rdata), .int_n_oe(int_n_oe),
		.int_n_out(int_n_out), .addr(reg_addr), .wdata(reg_wdata), .wr(reg_wr),
		.rd(reg_rd), .int_line(int_line));

	always #20 clk_sys = ~clk_sys;

	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t result %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		check_word({8'h00, got}, {8'h00, exp});
	endtask

	task automatic check_pin(input logic exp);
		checks++;
		if (int_line !== exp) begin
			num_errors++;
			$display("[ERR] %0t interrupt line %b expected %b", $time, int_line, exp);
		end
	endtask

	task automatic convert(input logic [15:0] r, input logic s);
		@(posedge clk_sys);
		conv_done <= 1'b1;
		conv <= '{raw: r, sat: s};
		@(posedge clk_sys);
		conv_done <= 1'b0;
		conv <= '{raw: ~r, sat: ~s};
	endtask

	task automatic flags_are(input logic [7:0] exp);
		i_host.read_reg(`REG_FLAGS, b);
		check_byte(b, exp);
	endtask

	task automatic trimmed(input logic [7:0] t, input logic [15:0] r, input logic [15:0] exp);
		i_host.write_reg(`REG_TRIM, t);
		convert(r, 1'b0);
		i_host.read_result(w);
		check_word(w, exp);
	endtask

	task automatic tally_and_finish;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		reset = 1'b1;
		conv_done = 1'b0;
		conv = '0;
		int_clear = 1'b0;
		num_errors = 0;
		checks = 0;
		cfg = '{front_end_gain_select: 2'h0, emitter_current_select: 2'h3,
			emitter_pulse_count: 8'h08, interrupt_filter_count: 4'h0, int_enable: 1'b1,
			thr_low: 16'h0000, thr_high: 16'hffff};
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		flags_are(8'h00);
		i_host.read_reg(`REG_TRIM, b);
		check_byte(b, `TRIM_RESET);
		i_host.read_reg(`REG_HIGH, b);
		check_byte(b, 8'h00);
		i_host.read_reg(8'h20, b);
		check_byte(b, 8'h00);
		check_pin(1'b1);
		convert(16'h1234, 1'b0);
		i_host.read_result(w);
		check_word(w, 16'h1234);
		flags_are(8'h22);
		check_pin(1'b0);
		i_host.write_reg(`REG_FLAGS, 8'hff);
		flags_are(8'h22);
		i_host.read_reg(`REG_LOW, b);
		check_byte(b, 8'h34);
		convert(16'habcd, 1'b0);
		i_host.read_reg(`REG_HIGH, b);
		check_byte(b, 8'h12);
		i_host.read_result(w);
		check_word(w, 16'habcd);
		@(posedge clk_sys);
		int_clear <= 1'b1;
		@(posedge clk_sys);
		int_clear <= 1'b0;
		flags_are(8'h02);
		check_pin(1'b1);
		i_host.write_reg(`REG_TRIM, 8'h85);
		i_host.read_reg(`REG_TRIM, b);
		check_byte(b, 8'h85);
		trimmed(8'h85, 16'h0100, 16'h0105);
		@(posedge clk_sys);
		cfg.front_end_gain_select <= 2'h1;
		cfg.emitter_current_select <= 2'h2;
		trimmed(8'h85, 16'h0100, 16'h0114);
		trimmed(8'h05, 16'h0100, 16'h00ec);
		@(posedge clk_sys);
		cfg.emitter_current_select <= 2'h0;
		trimmed(8'h81, 16'h0100, 16'h0110);
		trimmed(8'hff, 16'hfff0, 16'hffff);
		flags_are(8'h62);
		trimmed(8'h7f, 16'h0010, 16'h0000);
		flags_are(8'h22);
		i_host.write_reg(`REG_TRIM, 8'h00);
		convert(16'h0200, 1'b1);
		flags_are(8'h62);
		@(posedge clk_sys);
		cfg.interrupt_filter_count <= 4'h2;
		cfg.thr_high <= 16'h1000;
		int_clear <= 1'b1;
		@(posedge clk_sys);
		int_clear <= 1'b0;
		convert(16'h2000, 1'b0);
		flags_are(8'h02);
		convert(16'h0500, 1'b0);
		convert(16'h2000, 1'b0);
		flags_are(8'h02);
		convert(16'h2000, 1'b0);
		flags_are(8'h22);
		check_pin(1'b0);
		@(posedge clk_sys);
		cfg.int_enable <= 1'b0;
		int_clear <= 1'b1;
		@(posedge clk_sys);
		int_clear <= 1'b0;
		convert(16'h2000, 1'b0);
		flags_are(8'h02);
		@(posedge clk_sys);
		cfg.int_enable <= 1'b1;
		cfg.interrupt_filter_count <= 4'h1;
		cfg.thr_low <= 16'h0100;
		convert(16'h0050, 1'b0);
		flags_are(8'h22);
		check_pin(1'b0);
		tally_and_finish();
	end
endmodule
